//--- pfs_consts.vh
// Purpose: Shared constants of the pin function select block
// Assumes: Byte addresses on a 28-bit register port
// Notes:   Definitions only
`ifndef PFS_CONSTS_VH
`define PFS_CONSTS_VH

// ==========================================================
// Register byte addresses
`define PFS_ADDR_DIR_A 28'h5FFFFC4
`define PFS_ADDR_DIR_B 28'h5FFFFC6
`define PFS_ADDR_FUNC_A_UP 28'h5FFFFC8
`define PFS_ADDR_FUNC_A_LO 28'h5FFFFCA
`define PFS_ADDR_FUNC_B_UP 28'h5FFFFCC
`define PFS_ADDR_FUNC_B_LO 28'h5FFFFCE
`define PFS_ADDR_COL_STROBE 28'h5FFFFEE

// ==========================================================
// Reset values
`define PFS_RST_DIR_A 16'h0000
`define PFS_RST_DIR_B 16'h0000
`define PFS_RST_FUNC_A_UP 16'h3302
`define PFS_RST_FUNC_A_LO 16'hFF95
`define PFS_RST_FUNC_B_UP 16'h0000
`define PFS_RST_FUNC_B_LO 16'h0000
`define PFS_RST_COL_STROBE 16'h5FFF

// ==========================================================
// Writable bits (bit 1 of the upper port A select is fixed)
`define PFS_WMASK_ALL 16'hFFFF
`define PFS_WMASK_FUNC_A_UP 16'hFFFD

// ==========================================================
// Access sizes
`define PFS_SIZE_BYTE 2'h0
`define PFS_SIZE_HALF 2'h1
`define PFS_SIZE_WORD 2'h2

// ==========================================================
// Function codes and slot masks (bit = 3 * pin + code - 1)
`define PFS_CODE_PORT 2'h0
`define PFS_COL_SEL_STROBE 2'h2
`define PFS_COL_HI_BIT 15
`define PFS_COL_LO_BIT 13
`define PFS_TIMER_MASK_A 48'h000480000082
`define PFS_TIMER_MASK_B 48'h000000009249
`define PFS_RSVD_MASK_A 48'h400000000000
`define PFS_RSVD_MASK_B 48'h000000000000
`define PFS_SLOT_UPPER_WR 15
`define PFS_SLOT_LOWER_WR 12

`endif

//--- pfs_monitor.sv
// Purpose: Port-level checks of the pin function select block
// Assumes: One clock; srst is the power-on reset
// Notes:   Bound to the top module below
`timescale 1ns/10ps
`include "pfs_consts.vh"
module pfs_monitor (
  // Clock and reset
  input logic sys_clk,
  input logic srst,
  // Register port
  input logic [27:0] busAddr,
  input logic [1:0] busSize,
  input logic busWr,
  input logic busRd,
  input logic [31:0] busRdata,
  // Port B and column strobe pin
  input logic [15:0] portBOut,
  input logic [47:0] periphBOut,
  input logic [47:0] periphBOe,
  input logic [15:0] padBIn,
  input logic [15:0] padBOut,
  input logic [15:0] padBOeN,
  input logic [15:0] pinLevelB,
  input logic chipSel1,
  input logic upperColumnStrobe,
  input logic csPin1Out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [1:0] upCnt_q;
  // ==========================================
  // Edges since reset: sync history needs two
  always_ff @(posedge sys_clk) begin
    if (srst) upCnt_q <= 2'h0;
    else if (upCnt_q != 2'h3) upCnt_q <= upCnt_q + 2'h1;
  end
  sequence quietB;
    !busWr && $stable({portBOut, periphBOut, periphBOe});
  endsequence
  sequence quietCs;
    !busWr && $stable({chipSel1, upperColumnStrobe});
  endsequence
  rst_rdata_a: assert property (disable iff (1'b0) srst |=> busRdata == 32'h0)
    else $error("read data not cleared by reset");
  rst_oe_b_a: assert property (disable iff (1'b0) srst |=> padBOeN == 16'hFFFF)
    else $error("port B pad driven after reset");
  sync_level_a: assert property (upCnt_q == 2'h3 |-> pinLevelB == $past(padBIn, 2))
    else $error("pin level B not two edges behind pad");
  rdata_hold_a: assert property (!busRd |=> $stable(busRdata))
    else $error("read data moved without a read");
  fixed_bit_a: assert property (busRd && busAddr == `PFS_ADDR_FUNC_A_UP
    && busSize == `PFS_SIZE_HALF |=> busRdata[1])
    else $error("fixed bit of upper port A select read 0");
  word_read_a: assert property (busRd && busAddr == `PFS_ADDR_FUNC_A_UP
    && busSize == `PFS_SIZE_WORD |=> busRdata[17])
    else $error("word read misplaced upper port A select");
  pad_steady_a: assert property (quietB ##1 quietB |=> $stable({padBOut, padBOeN}))
    else $error("port B pad moved with steady selection");
  cs_steady_a: assert property (quietCs ##1 quietCs |=> $stable(csPin1Out))
    else $error("column strobe pin moved with steady sources");
endmodule // pfs_monitor
bind pfs_pin_function_select pfs_monitor pfs_monitor_i (.sys_clk, .srst, .busAddr,
  .busSize, .busWr, .busRd, .busRdata, .portBOut, .periphBOut, .periphBOe, .padBIn,
  .padBOut, .padBOeN, .pinLevelB, .chipSel1, .upperColumnStrobe, .csPin1Out);

//--- pfs_pad_model.sv
// Purpose: Pin level model for one sixteen-pin port
// Assumes: Undriven pins sit at the board level
// Notes:   Peripheral stimulus comes from the bench
`timescale 1ns/10ps
module pfs_pad_model (
  // Block side
  input logic [15:0] padOut,
  input logic [15:0] padOeN,
  // Board side
  input logic [15:0] boardLevel,
  output logic [15:0] padIn
);
  // ==========================================
  // Pin level
  assign padIn = (padOut & ~padOeN) | (boardLevel & padOeN);
endmodule // pfs_pad_model

//--- pfs_pin_function_select.v
// Purpose: Pin function select registers and pad routing for two ports
// Assumes: srst is the power-on reset; big-endian byte lanes
// Notes:   Reads answer one cycle after the read strobe
`timescale 1ns/10ps
`include "pfs_consts.vh"

// Summary of operation
// - Function and direction are set per pin by software, independent of chip mode.
// - Each multiplexed pin is routed to exactly one of port I/O or up to three peripherals.
// - The choice of write strobe pair on the two strobe pins comes from the bus unit config.
// - The upper port A select register is read/write and resets to 3302.
// - The lower port A select register is read/write and resets to FF95.
// - Both port B select registers are read/write and reset to 0000.
// - The column strobe select register is read/write and resets to 5FFF.
// - Every register takes byte, halfword and word accesses.
// - A direction bit of 1 makes the pin an output, 0 an input, in port or timer use.
// - Registers initialise only on power-on reset and hold through other resets.
// - Top port A pin mode 00 is I/O, 01 irq line, 11 DMA request, 10 reserved.
module pfs_pin_function_select (
  // Clock and power-on reset
  input wire sys_clk,
  input wire srst,
  // Register port
  input wire [27:0] busAddr,
  input wire [1:0] busSize,
  input wire [31:0] busWdata,
  input wire busWr,
  input wire busRd,
  output reg [31:0] busRdata,
  // Bus state unit config and strobes
  input wire strobeAltSel,
  input wire upperByteWriteStrobe,
  input wire lowerByteSelect,
  input wire lowerByteWriteStrobe,
  input wire plainWriteStrobe,
  // Port A
  input wire [15:0] portAOut,
  input wire [47:0] periphAOut,
  input wire [47:0] periphAOe,
  input wire [15:0] padAIn,
  output wire [15:0] padAOut,
  output wire [15:0] padAOeN,
  output wire [15:0] pinLevelA,
  // Port B
  input wire [15:0] portBOut,
  input wire [47:0] periphBOut,
  input wire [47:0] periphBOe,
  input wire [15:0] padBIn,
  output wire [15:0] padBOut,
  output wire [15:0] padBOeN,
  output wire [15:0] pinLevelB,
  // Chip select / column strobe pins
  input wire chipSel1,
  input wire chipSel3,
  input wire upperColumnStrobe,
  input wire lowerColumnStrobe,
  output reg csPin1Out,
  output reg csPin3Out
);

  // ==========================================================
  // Register map helpers
  localparam REG_COUNT = 7;
  localparam IDX_FUNC_A_UP = 2;

  function [27:0] regAddr;
    input integer i;
    begin
      case (i)
        0: regAddr = `PFS_ADDR_DIR_A;
        1: regAddr = `PFS_ADDR_DIR_B;
        2: regAddr = `PFS_ADDR_FUNC_A_UP;
        3: regAddr = `PFS_ADDR_FUNC_A_LO;
        4: regAddr = `PFS_ADDR_FUNC_B_UP;
        5: regAddr = `PFS_ADDR_FUNC_B_LO;
        default: regAddr = `PFS_ADDR_COL_STROBE;
      endcase
    end
  endfunction

  function [15:0] resetVal;
    input integer i;
    begin
      case (i)
        0: resetVal = `PFS_RST_DIR_A;
        1: resetVal = `PFS_RST_DIR_B;
        2: resetVal = `PFS_RST_FUNC_A_UP;
        3: resetVal = `PFS_RST_FUNC_A_LO;
        4: resetVal = `PFS_RST_FUNC_B_UP;
        5: resetVal = `PFS_RST_FUNC_B_LO;
        default: resetVal = `PFS_RST_COL_STROBE;
      endcase
    end
  endfunction

  // Lane (0 = bits 7:0) of byte x within the access, 4 when outside it
  function [2:0] laneOf;
    input [27:0] x;
    input [27:0] base;
    input [1:0] sz;
    reg [27:0] diff;
    reg [2:0] n;
    begin
      diff = x - base;
      case (sz)
        `PFS_SIZE_BYTE: n = 3'h1;
        `PFS_SIZE_HALF: n = 3'h2;
        default: n = 3'h4;
      endcase
      if (x >= base && diff < {25'h0, n}) begin
        laneOf = n - 3'h1 - diff[2:0];
      end else begin
        laneOf = 3'h4;
      end
    end
  endfunction

  // Merge write data into one register; even address holds the high byte
  function [15:0] mergeReg;
    input [15:0] old;
    input integer i;
    input [27:0] addr;
    input [1:0] sz;
    input [31:0] wd;
    reg [2:0] hi;
    reg [2:0] lo;
    reg [15:0] nv;
    reg [15:0] wm;
    begin
      hi = laneOf(regAddr(i), addr, sz);
      lo = laneOf(regAddr(i) + 28'h1, addr, sz);
      nv = old;
      if (hi != 3'h4) begin
        nv[15:8] = wd[8*hi +: 8];
      end
      if (lo != 3'h4) begin
        nv[7:0] = wd[8*lo +: 8];
      end
      // Fixed bit keeps its reset value whatever lane hits it
      wm = (i == IDX_FUNC_A_UP) ? `PFS_WMASK_FUNC_A_UP : `PFS_WMASK_ALL;
      mergeReg = (nv & wm) | (old & ~wm);
    end
  endfunction

  // Two-way pick, shared by the strobe pair and the chip select pins
  function pick2;
    input sel;
    input whenSet;
    input whenClear;
    begin
      pick2 = sel ? whenSet : whenClear;
    end
  endfunction

  // Column strobe field decode, shared by both chip select pins
  function colStrobeSel;
    input [1:0] field;
    begin
      colStrobeSel = (field == `PFS_COL_SEL_STROBE);
    end
  endfunction

  // ==========================================================
  // Registers: only srst (power-on) initialises them
  reg [15:0] regs_q [0:6];
  reg [31:0] rdData_d;
  reg [2:0] rdHi;
  reg [2:0] rdLo;
  integer i;
  integer j;

  always @(posedge sys_clk) begin
    for (i = 0; i < REG_COUNT; i = i + 1) begin
      if (srst) begin
        regs_q[i] <= resetVal(i);
      end else if (busWr) begin
        regs_q[i] <= mergeReg(regs_q[i], i, busAddr, busSize, busWdata);
      end
    end
  end

  // Unmapped bytes read as zero
  always @* begin
    rdData_d = 32'h00000000;
    rdHi = 3'h4;
    rdLo = 3'h4;
    // Own loop index, so no variable is driven from two processes
    for (j = 0; j < REG_COUNT; j = j + 1) begin
      rdHi = laneOf(regAddr(j), busAddr, busSize);
      rdLo = laneOf(regAddr(j) + 28'h1, busAddr, busSize);
      if (rdHi != 3'h4) begin
        rdData_d[8*rdHi +: 8] = regs_q[j][15:8];
      end
      if (rdLo != 3'h4) begin
        rdData_d[8*rdLo +: 8] = regs_q[j][7:0];
      end
    end
  end

  // Read data holds between reads, so a late sample still sees it
  always @(posedge sys_clk) begin
    if (srst) begin
      busRdata <= 32'h00000000;
    end else if (busRd) begin
      busRdata <= rdData_d;
    end
  end

  // ==========================================================
  // Named views of the register array
  wire [15:0] dirA = regs_q[0];
  wire [15:0] dirB = regs_q[1];
  wire [15:0] funcAUp = regs_q[IDX_FUNC_A_UP];
  wire [15:0] funcALo = regs_q[3];
  wire [15:0] funcBUp = regs_q[4];
  wire [15:0] funcBLo = regs_q[5];

  // ==========================================================
  // Function codes; pin 8 of port A has a one-bit field
  // Its spare bit is tied to 0, so that pin never reaches slots two or three
  wire [31:0] codeA = {funcAUp[15:2], 1'b0, funcAUp[0], funcALo};
  wire [31:0] codeB = {funcBUp, funcBLo};

  // ==========================================================
  // Write strobe pair comes from the bus unit, not from here
  reg [47:0] periphAOutSel;

  always @* begin
    periphAOutSel = periphAOut;
    periphAOutSel[`PFS_SLOT_UPPER_WR] = pick2(strobeAltSel, lowerByteSelect,
                                              upperByteWriteStrobe);
    periphAOutSel[`PFS_SLOT_LOWER_WR] = pick2(strobeAltSel, plainWriteStrobe,
                                              lowerByteWriteStrobe);
  end

  // ==========================================================
  // Port muxes and pad level return
  // Pads move one edge after a register write or a source change
  pfs_pin_mux #(
    .TIMER_MASK(`PFS_TIMER_MASK_A),
    .RSVD_MASK(`PFS_RSVD_MASK_A)
  ) muxA (
    .sys_clk(sys_clk),
    .srst(srst),
    .funcCode(codeA),
    .dirBits(dirA),
    .portOut(portAOut),
    .periphOut(periphAOutSel),
    .periphOe(periphAOe),
    .padOut(padAOut),
    .padOeN(padAOeN)
  );

  pfs_pin_mux #(
    .TIMER_MASK(`PFS_TIMER_MASK_B),
    .RSVD_MASK(`PFS_RSVD_MASK_B)
  ) muxB (
    .sys_clk(sys_clk),
    .srst(srst),
    .funcCode(codeB),
    .dirBits(dirB),
    .portOut(portBOut),
    .periphOut(periphBOut),
    .periphOe(periphBOe),
    .padOut(padBOut),
    .padOeN(padBOeN)
  );

  // Pad level goes to port and peripherals alike
  // One synchroniser per port keeps every user on the same sampled level
  pfs_sync2 syncA (
    .sys_clk(sys_clk),
    .srst(srst),
    .asyncIn(padAIn),
    .syncOut(pinLevelA)
  );

  pfs_sync2 syncB (
    .sys_clk(sys_clk),
    .srst(srst),
    .asyncIn(padBIn),
    .syncOut(pinLevelB)
  );

  // ==========================================================
  // Chip select / column strobe pins
  wire [15:0] colReg = regs_q[6];
  reg csPin1_d;
  reg csPin3_d;

  // Chip select is the fallback for every field value but the strobe code
  always @* begin
    csPin1_d = pick2(colStrobeSel(colReg[`PFS_COL_HI_BIT -: 2]), upperColumnStrobe,
                     chipSel1);
    csPin3_d = pick2(colStrobeSel(colReg[`PFS_COL_LO_BIT -: 2]), lowerColumnStrobe,
                     chipSel3);
  end

  // Strobes idle high through reset, so no pin pulses low at power-on
  always @(posedge sys_clk) begin
    if (srst) begin
      csPin1Out <= 1'b1;
      csPin3Out <= 1'b1;
    end else begin
      csPin1Out <= csPin1_d;
      csPin3Out <= csPin3_d;
    end
  end

endmodule // pfs_pin_function_select

//--- pfs_pin_mux.v
// Purpose: Per-pin function mux for one sixteen-pin port
// Assumes: Two-bit code per pin, 0 selects port I/O
// Notes:   Pad outputs are registered; oe is active low
`timescale 1ns/10ps
`include "pfs_consts.vh"

module pfs_pin_mux #(
  parameter [47:0] TIMER_MASK = 48'h000000000000,
  parameter [47:0] RSVD_MASK = 48'h000000000000
) (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Selection
  input wire [31:0] funcCode,
  input wire [15:0] dirBits,
  // Sources
  input wire [15:0] portOut,
  input wire [47:0] periphOut,
  input wire [47:0] periphOe,
  // Pads
  output reg [15:0] padOut,
  output reg [15:0] padOeN
);

  reg [15:0] outD;
  reg [15:0] drvD;
  reg [1:0] code;
  integer p;
  integer s;

  // ==========================================================
  // One source per pin
  always @* begin
    outD = 16'h0000;
    drvD = 16'h0000;
    code = 2'h0;
    s = 0;
    for (p = 0; p < 16; p = p + 1) begin
      code = funcCode[2*p +: 2];
      if (code == `PFS_CODE_PORT) begin
        outD[p] = portOut[p];
        drvD[p] = dirBits[p];
      end else begin
        s = 3 * p + code - 1;
        outD[p] = periphOut[s];
        // Reserved code leaves the pin undriven
        if (RSVD_MASK[s]) begin
          drvD[p] = 1'b0;
        end else if (TIMER_MASK[s]) begin
          drvD[p] = dirBits[p];
        end else begin
          drvD[p] = periphOe[s];
        end
      end
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      padOut <= 16'h0000;
      padOeN <= 16'hFFFF;
    end else begin
      padOut <= outD;
      padOeN <= ~drvD;
    end
  end

endmodule // pfs_pin_mux

//--- pfs_sync2.v
// Purpose: Two-flop synchroniser for sixteen pad levels
// Assumes: Pads are asynchronous to sys_clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps

module pfs_sync2 (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Levels
  input wire [15:0] asyncIn,
  output reg [15:0] syncOut
);

  reg [15:0] meta_q;

  always @(posedge sys_clk) begin
    if (srst) begin
      meta_q <= 16'h0000;
      syncOut <= 16'h0000;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule // pfs_sync2

//--- tb.sv
// Purpose: Self-checking bench of the pin function select block
// Assumes: 25 MHz clock, synchronous power-on reset
// Notes:   Bus inputs change by NBA at rising edges
`timescale 1ns/10ps
`include "pfs_consts.vh"
module tb;
  logic sys_clk = 1'b0, srst = 1'b1, busWr = 1'b0, busRd = 1'b0, strobeAltSel = 1'b0;
  logic [27:0] busAddr = 28'h0;
  logic [1:0] busSize = 2'h0;
  logic [31:0] busWdata = 32'h0, busRdata;
  logic upperByteWriteStrobe = 1'b0, lowerByteSelect = 1'b0;
  logic lowerByteWriteStrobe = 1'b0, plainWriteStrobe = 1'b0;
  logic chipSel1 = 1'b0, chipSel3 = 1'b0, upperColumnStrobe = 1'b0, lowerColumnStrobe = 1'b0;
  logic [15:0] portAOut = 16'h0, portBOut = 16'h0, boardA = 16'h0, boardB = 16'h0;
  logic [47:0] periphAOut = 48'h0, periphAOe = 48'h0, periphBOut = 48'h0, periphBOe = 48'h0;
  logic [15:0] padAIn, padAOut, padAOeN, pinLevelA, padBIn, padBOut, padBOeN, pinLevelB;
  logic csPin1Out, csPin3Out;
  int miscompares = 0, comparisons = 0, cycles = 0;
  always #20 sys_clk = ~sys_clk;
  pfs_pin_function_select pfs_pin_function_select_i (.sys_clk, .srst, .busAddr, .busSize,
    .busWdata, .busWr, .busRd, .busRdata, .strobeAltSel, .upperByteWriteStrobe,
    .lowerByteSelect, .lowerByteWriteStrobe, .plainWriteStrobe, .portAOut, .periphAOut,
    .periphAOe, .padAIn, .padAOut, .padAOeN, .pinLevelA, .portBOut, .periphBOut,
    .periphBOe, .padBIn, .padBOut, .padBOeN, .pinLevelB, .chipSel1, .chipSel3,
    .upperColumnStrobe, .lowerColumnStrobe, .csPin1Out, .csPin3Out);
  pfs_pad_model padModelA (.padOut(padAOut), .padOeN(padAOeN), .boardLevel(boardA),
    .padIn(padAIn));
  pfs_pad_model padModelB (.padOut(padBOut), .padOeN(padBOeN), .boardLevel(boardB),
    .padIn(padBIn));
  // ==========================================
  // Shared tasks
  task automatic finish_test;
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [27:0] a, input logic [1:0] s, input logic [31:0] d);
    @(posedge sys_clk);
    busAddr <= a;
    busSize <= s;
    busWdata <= d;
    busWr <= 1'b1;
    @(posedge sys_clk);
    busWr <= 1'b0;
  endtask
  task automatic rdc(input string what, input logic [27:0] a, input logic [1:0] s,
    input logic [31:0] exp);
    logic [31:0] m;
    m = (s == `PFS_SIZE_BYTE) ? 32'hFF : (s == `PFS_SIZE_HALF) ? 32'hFFFF : 32'hFFFFFFFF;
    @(posedge sys_clk);
    busAddr <= a;
    busSize <= s;
    busRd <= 1'b1;
    @(posedge sys_clk);
    busRd <= 1'b0;
    #1;
    chk(what, busRdata & m, exp);
  endtask
  // Generous wait: pads follow one edge, levels three
  task automatic settle;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task automatic reset_dut;
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset_values;
    rdc("dirA", `PFS_ADDR_DIR_A, `PFS_SIZE_HALF, 32'h0);
    rdc("dirB", `PFS_ADDR_DIR_B, `PFS_SIZE_HALF, 32'h0);
    rdc("funcAUp", `PFS_ADDR_FUNC_A_UP, `PFS_SIZE_HALF, 32'h3302);
    rdc("funcALo", `PFS_ADDR_FUNC_A_LO, `PFS_SIZE_HALF, 32'hFF95);
    rdc("funcB", `PFS_ADDR_FUNC_B_UP, `PFS_SIZE_WORD, 32'h0);
    rdc("colStrobe", `PFS_ADDR_COL_STROBE, `PFS_SIZE_HALF, 32'h5FFF);
    rdc("unmapped", 28'h5FFFFD0, `PFS_SIZE_HALF, 32'h0);
  endtask
  task automatic t_access;
    wr(`PFS_ADDR_DIR_A, `PFS_SIZE_WORD, 32'h1234ABCD);
    rdc("dirA byte", `PFS_ADDR_DIR_A, `PFS_SIZE_BYTE, 32'h12);
    rdc("dirB", `PFS_ADDR_DIR_B, `PFS_SIZE_HALF, 32'hABCD);
    wr(`PFS_ADDR_DIR_B + 28'h1, `PFS_SIZE_BYTE, 32'h5A);
    rdc("dirB lane", `PFS_ADDR_DIR_B, `PFS_SIZE_HALF, 32'hAB5A);
    wr(`PFS_ADDR_FUNC_A_UP, `PFS_SIZE_HALF, 32'hC000);
    rdc("funcA word", `PFS_ADDR_FUNC_A_UP, `PFS_SIZE_WORD, 32'hC002FF95);
  endtask
  task automatic t_port_b;
    wr(`PFS_ADDR_DIR_B, `PFS_SIZE_HALF, 32'h00FF);
    portBOut <= 16'hA5A5;
    boardB <= 16'h5A5A;
    settle;
    chk("oeB", padBOeN, 16'hFF00);
    chk("outB", padBOut & 16'h00FF, 16'h00A5);
    chk("levelB", pinLevelB, 16'h5AA5);
    wr(`PFS_ADDR_FUNC_B_LO, `PFS_SIZE_HALF, 32'h0001);
    settle;
    chk("timer pin", {padBOut[0], padBOeN[0]}, 2'b00);
  endtask
  task automatic t_periph;
    wr(`PFS_ADDR_FUNC_B_UP, `PFS_SIZE_HALF, 32'h0002);
    periphBOut <= 48'h000002000000;
    periphBOe <= 48'h000002000000;
    settle;
    chk("periph pin", {padBOut[8], padBOeN[8]}, 2'b10);
    @(posedge sys_clk);
    periphBOe <= 48'h000001000000;
    settle;
    chk("unselected slot", padBOeN[8], 1'b1);
  endtask
  task automatic t_top_pin;
    logic [1:0] expTab [4] = '{2'b10, 2'b10, 2'b11, 2'b00};
    wr(`PFS_ADDR_DIR_A, `PFS_SIZE_HALF, 32'h8000);
    portAOut <= 16'h8000;
    periphAOe <= 48'hE00000000000;
    periphAOut <= 48'h600000000000;
    for (int c = 0; c < 4; c++) begin
      wr(`PFS_ADDR_FUNC_A_UP, `PFS_SIZE_BYTE, {24'h0, c[1:0], 6'h0});
      settle;
      chk("top pin", {padAOut[15] | (c == 2), padAOeN[15]}, expTab[c]);
      chk("top level", pinLevelA[15], c < 2);
    end
  endtask
  task automatic t_strobes;
    wr(`PFS_ADDR_FUNC_A_LO, `PFS_SIZE_HALF, 32'h0500);
    for (int s = 0; s < 2; s++) begin
      @(posedge sys_clk);
      strobeAltSel <= s[0];
      {upperByteWriteStrobe, lowerByteSelect, lowerByteWriteStrobe, plainWriteStrobe}
        <= s ? 4'b0110 : 4'b1001;
      settle;
      chk("strobe pair", {padAOut[5], padAOut[4]}, 2'b10);
    end
    @(posedge sys_clk);
    upperColumnStrobe <= 1'b1;
    settle;
    chk("cs pins", {csPin1Out, csPin3Out}, 2'b00);
    wr(`PFS_ADDR_COL_STROBE, `PFS_SIZE_BYTE, 32'hBF);
    settle;
    chk("column strobe pin", csPin1Out, 1'b1);
    @(posedge sys_clk);
    lowerColumnStrobe <= 1'b1;
    wr(`PFS_ADDR_COL_STROBE, `PFS_SIZE_BYTE, 32'hAF);
    settle;
    chk("column strobe pins", {csPin1Out, csPin3Out}, 2'b11);
  endtask
  // ==========================================
  // Main sequence and hang guard
  initial begin
    reset_dut;
    t_reset_values;
    t_access;
    t_port_b;
    t_periph;
    t_top_pin;
    t_strobes;
    reset_dut;
    t_reset_values;
    finish_test;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test;
    end
  end
endmodule // tb
